// File: hdl/ascp_pkg.sv
// constants, state codes and shared helpers for the converter serial control port
package ascp_pkg;

   // ==========================================================================
   // timing
   localparam int CLOCK_PERIOD_NS  = 5;
   localparam int CS_FILTER_NS     = 1425;
   localparam int CS_FILTER_CYCLES = (CS_FILTER_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam int CONV_TIME_NS     = 21000;
   localparam int CONV_CYCLES      = CONV_TIME_NS / CLOCK_PERIOD_NS;

   // ==========================================================================
   // widths and counts
   localparam int RES_BITS  = 10;
   localparam int ADDR_BITS = 4;
   localparam int CNT_BITS  = 5;
   localparam int PTR_BITS  = 4;
   localparam int FILT_BITS = 9;
   localparam int CONV_BITS = 16;
   localparam logic [CNT_BITS-1:0]  CNT_ADDR   = 5'h04;
   localparam logic [CNT_BITS-1:0]  CNT_SHORT  = 5'h0a;
   localparam logic [CNT_BITS-1:0]  CNT_LONG   = 5'h10;
   localparam logic [FILT_BITS-1:0] FILT_LAST  = FILT_BITS'(CS_FILTER_CYCLES - 1);

   // ==========================================================================
   // codes and self-test channel addresses
   localparam logic [RES_BITS-1:0]  CODE_ALL_ONES  = 10'h3ff;
   localparam logic [RES_BITS-1:0]  CODE_ZERO      = 10'h000;
   localparam logic [RES_BITS-1:0]  CODE_MID       = 10'h200;
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_MID  = 4'hb;
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_ZERO = 4'hc;
   localparam logic [ADDR_BITS-1:0] ADDR_TEST_FULL = 4'hd;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_XFER = 4'h2,
      ST_CONV = 4'h4,
      ST_TAIL = 4'h8
   } ascp_state_type;

   // ==========================================================================
   // helpers
   function automatic logic [PTR_BITS-1:0] ascp_bin2gray(input logic [PTR_BITS-1:0] b);
      return b ^ (b >> 1);
   endfunction

   function automatic logic [PTR_BITS-1:0] ascp_gray2bin(input logic [PTR_BITS-1:0] g);
      logic [PTR_BITS-1:0] b;
      b[PTR_BITS-1] = g[PTR_BITS-1];
      for (int i = PTR_BITS - 2; i >= 0; i--) begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

   // result for a channel: self-test voltages first, then rail clipping
   function automatic logic [RES_BITS-1:0] ascp_code_sel(
      input logic [ADDR_BITS-1:0] chan,
      input logic [RES_BITS-1:0]  code,
      input logic                 over,
      input logic                 under);
      logic [RES_BITS-1:0] r;
      r = code;
      if (chan == ADDR_TEST_MID) begin
         r = CODE_MID;
      end else if (chan == ADDR_TEST_ZERO) begin
         r = CODE_ZERO;
      end else if (chan == ADDR_TEST_FULL) begin
         r = CODE_ALL_ONES;
      end else if (over) begin
         r = CODE_ALL_ONES;
      end else if (under) begin
         r = CODE_ZERO;
      end
      return r;
   endfunction

endpackage

// File: hdl/ascp_port.sv
// serial control and result port of a 10-bit successive-approximation converter
//
// Contract
// - inputs above high reference read all ones, below low reference all zeros
// - address in and result out are plain positive logic, never inverted
// - a select change counts only after it holds for the filter time
// - after select falls, serial inputs are ignored until the filter time passes
// - select rising stops address and clock response within the filter time
// - transfers are ten clocks framed or unframed, eleven to sixteen framed, or sixteen unframed
// - data output goes high impedance once select is released
// - result MSB is driven after select falls, before any serial clock
// - self-test addresses give mid-scale, zero and full-scale codes
// - end-of-conversion falls after the tenth falling serial clock edge
// - whole access, sample and conversion cycle is bounded by 21 us plus clocks
`timescale 1ns/1ps
module ascp_port
   import ascp_pkg::*;
#(
   parameter int CONV_LEN = CONV_CYCLES
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 io_clk,
   input  wire logic                 cs_n,
   input  wire logic                 address_in,
   input  wire logic [RES_BITS-1:0]  analog_code,
   input  wire logic                 analog_over,
   input  wire logic                 analog_under,
   output logic                      data_out,
   output logic                      data_oe,
   output logic                      eoc,
   output logic [ADDR_BITS-1:0]      chan_sel
);

   localparam logic [CONV_BITS-1:0] CONV_LAST = CONV_BITS'(CONV_LEN - 1);

   // ==========================================================================
   // link domain: count serial clock edges, park address bits by edge number
   logic                rst_io_meta_reg;
   logic                rst_io_reg;
   logic [PTR_BITS-1:0] wptr_reg;
   logic [PTR_BITS-1:0] wptr_next;
   logic [PTR_BITS-1:0] fptr_reg;
   logic [PTR_BITS-1:0] fptr_next;
   logic                addr_mem [0:7];
   logic [PTR_BITS-1:0] wbin;
   // link reset follows rst only on serial clock edges: clock it deselected after release
   always_ff @(posedge io_clk) begin
      rst_io_meta_reg <= rst;
      rst_io_reg      <= rst_io_meta_reg;
   end
   // gray pointers: one bit changes per edge, so the system side never sees a torn word
   always_comb begin
      wbin      = ascp_gray2bin(wptr_reg);
      wptr_next = ascp_bin2gray(wbin + 4'h1);
      fptr_next = ascp_bin2gray(ascp_gray2bin(fptr_reg) + 4'h1);
   end
   always_ff @(posedge io_clk) begin
      if (rst_io_reg) begin
         wptr_reg <= 4'h0;
      end else begin
         addr_mem[wbin[2:0]] <= address_in;
         wptr_reg <= wptr_next;
      end
   end
   always_ff @(negedge io_clk) begin
      if (rst_io_reg) begin
         fptr_reg <= 4'h0;
      end else begin
         fptr_reg <= fptr_next;
      end
   end

   // ==========================================================================
   // system domain: synchronisers and select filter
   logic                 cs_meta_reg;
   logic                 cs_sync_reg;
   logic                 cs_filt_reg;
   logic                 cs_filt_next;
   logic                 cs_filt_d_reg;
   logic [FILT_BITS-1:0] filt_cnt_reg;
   logic [FILT_BITS-1:0] filt_cnt_next;
   logic [PTR_BITS-1:0]  wptr_meta_reg;
   logic [PTR_BITS-1:0]  wptr_sync_reg;
   logic [PTR_BITS-1:0]  fptr_meta_reg;
   logic [PTR_BITS-1:0]  fptr_sync_reg;
   logic [PTR_BITS-1:0]  rbin_reg;
   logic [PTR_BITS-1:0]  fbin_reg;
   logic                 rise_evt;
   logic                 fall_evt;
   logic                 sel_act;
   logic                 sel_start;
   logic                 oe_next;

   // a level change is taken only after it has held the whole filter window
   always_comb begin
      cs_filt_next  = cs_filt_reg;
      filt_cnt_next = '0;
      if (cs_sync_reg != cs_filt_reg) begin
         filt_cnt_next = filt_cnt_reg + 9'h001;
         if (filt_cnt_reg == FILT_LAST) begin
            cs_filt_next  = cs_sync_reg;
            filt_cnt_next = '0;
         end
      end
      oe_next   = ~cs_sync_reg;
      rise_evt  = rbin_reg != ascp_gray2bin(wptr_sync_reg);
      fall_evt  = fbin_reg != ascp_gray2bin(fptr_sync_reg);
      sel_act   = ~cs_filt_reg;
      sel_start = ~cs_filt_reg & cs_filt_d_reg;
   end
   always_ff @(posedge clock) begin
      cs_meta_reg   <= cs_n;
      cs_sync_reg   <= cs_meta_reg;
      wptr_meta_reg <= wptr_reg;
      wptr_sync_reg <= wptr_meta_reg;
      fptr_meta_reg <= fptr_reg;
      fptr_sync_reg <= fptr_meta_reg;
      if (rst) begin
         cs_filt_reg   <= 1'b1;
         cs_filt_d_reg <= 1'b1;
         filt_cnt_reg  <= '0;
         data_oe       <= 1'b0;
         rbin_reg      <= 4'h0;
         fbin_reg      <= 4'h0;
      end else begin
         cs_filt_reg   <= cs_filt_next;
         cs_filt_d_reg <= cs_filt_reg;
         filt_cnt_reg  <= filt_cnt_next;
         data_oe       <= oe_next;
         // every edge is consumed; only a selected one is acted on
         rbin_reg      <= rise_evt ? rbin_reg + 4'h1 : rbin_reg;
         fbin_reg      <= fall_evt ? fbin_reg + 4'h1 : fbin_reg;
      end
   end

   // ==========================================================================
   // transfer and conversion sequencer
   ascp_state_type        state_reg;
   ascp_state_type        state_next;
   logic [CNT_BITS-1:0]   rcnt_reg;
   logic [CNT_BITS-1:0]   rcnt_next;
   logic [CNT_BITS-1:0]   fcnt_reg;
   logic [CNT_BITS-1:0]   fcnt_next;
   logic [ADDR_BITS-1:0]  addr_reg;
   logic [ADDR_BITS-1:0]  addr_next;
   logic [ADDR_BITS-1:0]  chan_next;
   logic [RES_BITS-1:0]   out_reg;
   logic [RES_BITS-1:0]   out_next;
   logic [RES_BITS-1:0]   result_reg;
   logic [RES_BITS-1:0]   result_next;
   logic [RES_BITS-1:0]   new_code;
   logic [CONV_BITS-1:0]  timer_reg;
   logic [CONV_BITS-1:0]  timer_next;
   logic                  eoc_next;
   logic                  rise_acc;
   logic                  fall_acc;
   logic                  start_frame;

   always_comb begin
      state_next  = state_reg;
      addr_next   = addr_reg;
      chan_next   = chan_sel;
      out_next    = out_reg;
      result_next = result_reg;
      timer_next  = timer_reg;
      eoc_next    = eoc;
      start_frame = 1'b0;
      rise_acc    = rise_evt & sel_act;
      fall_acc    = fall_evt & sel_act;
      new_code    = ascp_code_sel(chan_sel, analog_code, analog_over, analog_under);
      // counting edges goes on through conversion to spot a long frame
      rcnt_next   = rcnt_reg + CNT_BITS'(rise_acc);
      fcnt_next   = fcnt_reg + CNT_BITS'(fall_acc);
      unique case (state_reg)
         ST_IDLE: begin
            out_next    = result_reg; // MSB ready while select is still filtering
            start_frame = sel_act;
         end
         ST_XFER: begin
            if (!sel_act) begin
               state_next = ST_IDLE;
            end else begin
               if (rise_acc && rcnt_reg < CNT_ADDR) begin
                  addr_next = {addr_reg[ADDR_BITS-2:0], addr_mem[rbin_reg[2:0]]};
               end
               if (fall_acc) begin
                  if (fcnt_reg == CNT_SHORT - 5'h01) begin
                     state_next = ST_CONV;
                     eoc_next   = 1'b0;
                     chan_next  = addr_reg;
                     timer_next = CONV_LAST;
                  end else begin
                     out_next = {out_reg[RES_BITS-2:0], 1'b0};
                  end
               end
            end
         end
         ST_CONV: begin
            timer_next = timer_reg - 16'h0001;
            if (sel_start) begin
               eoc_next    = 1'b1; // a fresh select aborts, old result stays
               start_frame = 1'b1;
            end else if (timer_reg == '0) begin
               result_next = new_code;
               eoc_next    = 1'b1;
               if (!sel_act) begin
                  state_next = ST_IDLE;
               end else if (rcnt_next > CNT_SHORT) begin
                  state_next = ST_TAIL;
               end else begin
                  start_frame = 1'b1;
               end
            end
         end
         ST_TAIL: begin
            if (!sel_act) begin
               state_next = ST_IDLE;
            end else if (rcnt_next == CNT_LONG && fcnt_next == CNT_LONG) begin
               start_frame = 1'b1;
            end
         end
      endcase
      if (start_frame) begin
         state_next = ST_XFER;
         rcnt_next  = '0;
         fcnt_next  = '0;
         addr_next  = '0;
         out_next   = result_next;
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         state_reg  <= ST_IDLE;
         rcnt_reg   <= '0;
         fcnt_reg   <= '0;
         addr_reg   <= '0;
         chan_sel   <= '0;
         out_reg    <= '0;
         result_reg <= '0;
         timer_reg  <= '0;
         eoc        <= 1'b1;
      end else begin
         state_reg  <= state_next;
         rcnt_reg   <= rcnt_next;
         fcnt_reg   <= fcnt_next;
         addr_reg   <= addr_next;
         chan_sel   <= chan_next;
         out_reg    <= out_next;
         result_reg <= result_next;
         timer_reg  <= timer_next;
         eoc        <= eoc_next;
      end
   end
   assign data_out = out_reg[RES_BITS-1]; // bit of a flop, no gate in between

   // ==========================================================================
   // checks
   logic [CONV_BITS-1:0] eoc_low_cnt_reg;
   always_ff @(posedge clock) begin
      if (rst || eoc) begin
         eoc_low_cnt_reg <= '0;
      end else begin
         eoc_low_cnt_reg <= eoc_low_cnt_reg + 16'h0001;
      end
   end
   a_clip_high: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_CONV && timer_reg == '0 && !sel_start && analog_over
       && chan_sel < ADDR_TEST_MID) |=> result_reg == CODE_ALL_ONES)
      else $error("over-range input did not clip to all ones");
   a_clip_low: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_CONV && timer_reg == '0 && !sel_start && !analog_over
       && analog_under && chan_sel < ADDR_TEST_MID) |=> result_reg == CODE_ZERO)
      else $error("under-range input did not clip to zero");
   a_test_mid: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_CONV && timer_reg == '0 && !sel_start && chan_sel == ADDR_TEST_MID)
      |=> result_reg == CODE_MID)
      else $error("mid-scale self-test code wrong");
   a_filter_hold: assert property (@(posedge clock) disable iff (rst)
      $changed(cs_filt_reg) |-> $past(filt_cnt_reg) == FILT_LAST
                             && $past(cs_sync_reg) == cs_filt_reg)
      else $error("select accepted before the filter window");
   a_deselect_stop: assert property (@(posedge clock) disable iff (rst)
      $rose(cs_sync_reg) ##1 cs_sync_reg [*8] |-> ##[0:290] !sel_act)
      else $error("select release not taken in time");
   a_oe_release: assert property (@(posedge clock) disable iff (rst)
      cs_n |-> ##3 !data_oe)
      else $error("data output still driven after select release");
   a_msb_first: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_XFER && fcnt_reg == '0) |-> data_out == result_reg[RES_BITS-1])
      else $error("first bit is not the result MSB");
   a_eoc_fall: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_XFER && sel_act && fall_evt && fcnt_reg == CNT_SHORT - 5'h01)
      |=> !eoc && state_reg == ST_CONV && chan_sel == $past(addr_reg))
      else $error("conversion did not start on the tenth falling edge");
   a_conv_bound: assert property (@(posedge clock) disable iff (rst)
      eoc_low_cnt_reg <= CONV_LAST + 16'h0001)
      else $error("conversion ran past its time");
   a_shift_out: assert property (@(posedge clock) disable iff (rst)
      (state_reg == ST_XFER && sel_act && fall_evt && fcnt_reg < CNT_SHORT - 5'h01)
      |=> out_reg == {$past(out_reg[RES_BITS-2:0]), 1'b0})
      else $error("result did not shift on a falling edge");

endmodule // ascp_port

// File: testbench/ascp_host_model.sv
// host-side serial master that frames transfers and shifts address and result bits
`timescale 1ns/1ps
module ascp_host_model (
   output logic      io_clk,
   output logic      cs_n,
   output logic      address_in,
   input  wire logic data_pin
);
   // ==========================================================================
   // idle: select high, serial clock parked low between frames
   initial begin
      io_clk     = 1'b0;
      cs_n       = 1'b1;
      address_in = 1'b0;
   end

   // select, then hold off clocking until the port has had time to accept it
   task automatic select(input int settle_ns);
      cs_n = 1'b0;
      #(settle_ns);
   endtask

   // release select; the caller decides how long to stay away
   task automatic deselect();
      cs_n = 1'b1;
   endtask

   // ==========================================================================
   // back-to-back 80 ns clocks keep the 11th rising edge well ahead of conversion end
   task automatic shift(input logic [3:0] addr, input int n, output logic [9:0] got);
      got = '0;
      for (int i = 0; i < n; i++) begin
         address_in = (i < 4) ? addr[3-i] : 1'b0;
         #40;
         io_clk = 1'b1;
         #40;
         if (i < 10) begin
            got[9-i] = data_pin; // sampled while the bit still stands
         end
         io_clk = 1'b0;
      end
      #40;
      // no longer sampled: flip it so a stale level never passes for a valid one
      address_in = ~address_in;
   endtask
endmodule // ascp_host_model

// File: testbench/ascp_port_bench.sv
// self-checking bench for the converter serial control port
`timescale 1ns/1ps
module ascp_port_bench;
   import ascp_pkg::*;

   // ==========================================================================
   // short conversion keeps the run brief, yet an abort still lands inside it
   localparam int CONV_LEN = 1000;

   logic                 clock;
   logic                 rst;
   logic [RES_BITS-1:0]  analog_code;
   logic                 analog_over;
   logic                 analog_under;
   wire logic            io_clk;
   wire logic            cs_n;
   wire logic            address_in;
   logic                 data_out;
   logic                 data_oe;
   logic                 eoc;
   logic [ADDR_BITS-1:0] chan_sel;
   wire logic            data_pin;
   logic [RES_BITS-1:0]  got;
   int                   miscompares;
   int                   num_checks;

   // the pin floats whenever the port does not drive it
   assign data_pin = data_oe ? data_out : 1'bz;

   always #2.5 clock = ~clock;

   ascp_port #(.CONV_LEN(CONV_LEN)) ascp_port_i (
      .clock(clock), .rst(rst), .io_clk(io_clk), .cs_n(cs_n), .address_in(address_in),
      .analog_code(analog_code), .analog_over(analog_over), .analog_under(analog_under),
      .data_out(data_out), .data_oe(data_oe), .eoc(eoc), .chan_sel(chan_sel));

   ascp_host_model ascp_host_model_i (
      .io_clk(io_clk), .cs_n(cs_n), .address_in(address_in), .data_pin(data_pin));

   // ==========================================================================
   // shared helpers
   task automatic summarize();
      $display("checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // bounded wait on eoc; running out of patience ends the run
   task automatic wait_eoc(input logic lvl, input int limit);
      int k;
      k = 0;
      while (eoc !== lvl && k < limit) begin
         tick(1);
         k++;
      end
      if (eoc !== lvl) begin
         check("eoc wait", 16'(eoc), 16'(lvl));
         summarize();
      end
   endtask

   // one transfer: select or wait for eoc, msb first, shift, convert, maybe release
   task automatic xfer(input logic [3:0] addr, input int n, input logic sel, input logic rel,
                       input logic [9:0] prev);
      if (sel) begin
         ascp_host_model_i.select(1600);
      end else begin
         wait_eoc(1'b1, CONV_LEN + 20);
         tick(10);
      end
      check("msb before clock", 16'(data_pin), 16'(prev[9]));
      ascp_host_model_i.shift(addr, n, got);
      check("shifted result", 16'(got), 16'(prev));
      wait_eoc(1'b0, 20);
      check("channel", 16'(chan_sel), 16'(addr));
      wait_eoc(1'b1, CONV_LEN + 20);
      if (rel) begin
         ascp_host_model_i.deselect();
         tick(30);
         check("output enable", 16'(data_oe), 16'h0000);
         tick(300);
      end
   endtask

   // ==========================================================================
   // scenarios
   task automatic s_reset();
      check("reset enable", 16'(data_oe), 16'h0000);
      check("reset eoc", 16'(eoc), 16'h0001);
      check("reset channel", 16'(chan_sel), 16'h0000);
      check("reset data", 16'(data_out), 16'h0000);
   endtask

   // codes chain frame to frame: each transfer reads the previous conversion
   task automatic s_codes();
      logic [ADDR_BITS-1:0] adr[8];
      logic [RES_BITS-1:0]  code[8];
      logic [1:0]           rail[8];
      logic [RES_BITS-1:0]  prev;
      adr  = '{4'hb, 4'hc, 4'hd, 4'h3, 4'h5, 4'h2, 4'h4, 4'h6};
      code = '{10'h155, 10'h155, 10'h155, 10'h0aa, 10'h0aa, 10'h2a5, 10'h0f0, 10'h001};
      rail = '{2'h0, 2'h3, 2'h0, 2'h2, 2'h1, 2'h0, 2'h0, 2'h0};
      prev = CODE_ZERO;
      for (int i = 0; i < 8; i++) begin
         analog_code  = code[i];
         analog_over  = rail[i][1];
         analog_under = rail[i][0];
         xfer(adr[i], (i % 2 == 0) ? 10 : 16, i <= 5, i <= 4 || i == 7, prev);
         // self-test addresses win over the rails, the rails over the raw code
         case (adr[i])
            ADDR_TEST_MID:  prev = CODE_MID;
            ADDR_TEST_ZERO: prev = CODE_ZERO;
            ADDR_TEST_FULL: prev = CODE_ALL_ONES;
            default:        prev = rail[i][1] ? CODE_ALL_ONES : rail[i][0] ? CODE_ZERO : code[i];
         endcase
      end
   endtask

   // a select too short to count, then clocks with select released
   task automatic s_glitch();
      logic [ADDR_BITS-1:0] held;
      held = chan_sel;
      ascp_host_model_i.select(0);
      ascp_host_model_i.shift(4'h9, 3, got);
      ascp_host_model_i.deselect();
      tick(20);
      check("eoc after glitch", 16'(eoc), 16'h0001);
      tick(300);
      ascp_host_model_i.shift(4'h9, 10, got);
      tick(20);
      check("eoc while released", 16'(eoc), 16'h0001);
      check("channel after glitch", 16'(chan_sel), 16'(held));
   endtask

   // toggling select mid-conversion drops it and keeps the old result
   task automatic s_abort();
      ascp_host_model_i.select(1600);
      ascp_host_model_i.shift(4'hd, 10, got);
      check("result over glitch", 16'(got), 16'h0001);
      wait_eoc(1'b0, 20);
      ascp_host_model_i.deselect();
      tick(320);
      ascp_host_model_i.select(1600);
      check("eoc after abort", 16'(eoc), 16'h0001);
      ascp_host_model_i.shift(4'h1, 10, got);
      check("result after abort", 16'(got), 16'h0001);
      wait_eoc(1'b0, 20);
      wait_eoc(1'b1, CONV_LEN + 20);
      ascp_host_model_i.deselect();
      tick(30);
   endtask

   // ==========================================================================
   // reset stays up until the serial clock has given four edges for the link side
   initial begin
      clock        = 1'b0;
      rst          = 1'b1;
      analog_code  = '0;
      analog_over  = 1'b0;
      analog_under = 1'b0;
      miscompares  = 0;
      num_checks   = 0;
      tick(3);
      ascp_host_model_i.shift(4'h0, 4, got);
      tick(3);
      rst = 1'b0;
      tick(2);
      s_reset();
      // the link side leaves reset only on serial edges; these land deselected
      ascp_host_model_i.shift(4'h0, 4, got);
      tick(10);
      s_codes();
      s_glitch();
      s_abort();
      summarize();
   end
endmodule // ascp_port_bench
